// *** rtl/sdcl_top.sv ***
// divider configuration loader of a pll synthesizer, digital part only
// assumes pins are asynchronous, clk_sys stands in for the oscillator
`timescale 1ns/1ns
`include "sdcl_cfg.svh"

module sdcl_top #(
  parameter int FB_W = 9,
  parameter logic [15:0] OUT_RATIO_LOG2 = `SDCL_OUT_RATIO_LOG2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [FB_W-1:0] fb_div_bits,
  input wire logic [1:0] out_div_bits,
  input wire logic par_load_strobe_n,
  input wire logic ser_clock,
  input wire logic ser_data,
  input wire logic ser_load,
  input wire logic divider_reset,
  input wire logic ref_source_select,
  input wire logic pll_bypass_select,
  input wire logic xtal_clk,
  input wire logic ref_clk,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic synth_out,
  output logic synth_out_n,
  output logic test_out,
  output logic fb_div_out
);

  // ==========================================================
  // sizes and pin vector layout
  localparam int CW = FB_W + 4;
  localparam int PW = FB_W + 11;
  localparam int P_OUT = FB_W;
  localparam int P_PAR = FB_W + 2;
  localparam int P_SCLK = FB_W + 3;
  localparam int P_SDAT = FB_W + 4;
  localparam int P_SLD = FB_W + 5;
  localparam int P_MR = FB_W + 6;
  localparam int P_RSEL = FB_W + 7;
  localparam int P_BYP = FB_W + 8;
  localparam int P_XTAL = FB_W + 9;
  localparam int P_REF = FB_W + 10;
  localparam logic [7:0] OFS_CTRL = `SDCL_OFS_CTRL;
  localparam logic [7:0] OFS_STATUS = `SDCL_OFS_STATUS;
  localparam logic [7:0] OFS_SHIFT = `SDCL_OFS_SHIFT;
  localparam logic [FB_W-1:0] FB_ONE = {{(FB_W-1){1'b0}}, 1'b1};
  localparam logic [15:0] FB_MIN = `SDCL_FB_MIN;
  localparam logic [15:0] FB_MAX = `SDCL_FB_MAX;

  // the status word packs the config into 16 bits and must hold 28
  if (FB_W < 5 || FB_W > 11) begin : g_chk
    $error("fb divider width must be 5 to 11");
  end

  // ==========================================================
  // pin synchronisers
  logic [PW-1:0] s1_reg;
  logic [PW-1:0] s2_reg;
  logic [PW-1:0] s3_reg;
  logic [PW-1:0] pin_f_reg;
  logic [PW-1:0] pin_p_reg;
  wire [PW-1:0] pin_raw = {ref_clk, xtal_clk, pll_bypass_select, ref_source_select,
    divider_reset, ser_load, ser_data, ser_clock, par_load_strobe_n, out_div_bits,
    fb_div_bits};
  // a bit is accepted only when stages two and three agree, filtering glitches
  wire [PW-1:0] agree = ~(s2_reg ^ s3_reg);
  wire [PW-1:0] pin_f_next = (pin_f_reg & ~agree) | (s3_reg & agree);

  // three-stage capture, filtered level and its previous value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_f_reg <= '0;
      pin_p_reg <= '0;
    end else if (clk_en) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_f_reg <= pin_f_next;
      pin_p_reg <= pin_f_reg;
    end
  end

  // filtered levels and edges
  wire [PW-1:0] pin_rise = pin_f_reg & ~pin_p_reg;
  wire [PW-1:0] pin_fall = ~pin_f_reg & pin_p_reg;
  wire par_f = pin_f_reg[P_PAR];
  wire sdat_f = pin_f_reg[P_SDAT];
  wire sld_f = pin_f_reg[P_SLD];
  wire mr_f = pin_f_reg[P_MR];
  wire byp_f = pin_f_reg[P_BYP];
  wire sclk_rise = pin_rise[P_SCLK];
  wire sld_rise = pin_rise[P_SLD];
  wire sld_fall = pin_fall[P_SLD];

  // ==========================================================
  // configuration loading
  logic [FB_W-1:0] fb_reg;
  logic [1:0] out_reg;
  logic [1:0] test_reg;
  logic [CW-1:0] shift_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  sdcl_pkg::sdcl_mode_t mode_reg;
  sdcl_pkg::sdcl_mode_t mode_next;

  wire [CW-1:0] shift_next = (par_f && sclk_rise) ? {shift_reg[CW-2:0], sdat_f} : shift_reg;
  wire ser_xfer = par_f && (sld_rise || (sld_f && sclk_rise));
  // one capture once the synchronisers have filled
  wire strap_load = !strap_done_reg && (strap_cnt_reg == `SDCL_SYNC_FILL);
  // parallel pass while strobe is low
  wire par_load = !par_f || strap_load;
  // the filter takes the tied pins on the capture edge itself, so capture reads its input
  wire [PW-1:0] par_src = strap_load ? pin_f_next : pin_f_reg;

  always_comb begin
    if (!par_f) begin
      mode_next = sdcl_pkg::SDCL_MODE_PAR;
    end else if (sld_f) begin
      mode_next = sdcl_pkg::SDCL_MODE_PASS;
    end else begin
      mode_next = sdcl_pkg::SDCL_MODE_SHIFT;
    end
  end

  // parallel load wins over serial events; divider reset never touches these
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fb_reg <= '0;
      out_reg <= '0;
      test_reg <= '0;
      shift_reg <= '0;
      strap_cnt_reg <= '0;
      strap_done_reg <= `SDCL_CFG_RESET;
      mode_reg <= sdcl_pkg::SDCL_MODE_PAR;
    end else if (clk_en) begin
      shift_reg <= shift_next;
      mode_reg <= mode_next;
      if (strap_cnt_reg != `SDCL_SYNC_FILL) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_load) begin
        strap_done_reg <= 1'b1;
      end
      // values hold when no load event occurs
      if (par_load) begin
        fb_reg <= par_src[FB_W-1:0];
        out_reg <= par_src[P_OUT+1:P_OUT];
      end else if (ser_xfer) begin
        // test bits only arrive this way
        {test_reg, out_reg, fb_reg} <= shift_next;
      end
    end
  end

  // ==========================================================
  // divider chain
  logic ctrl_run_reg;
  logic [FB_W-1:0] fb_cnt_reg;
  logic [15:0] out_cnt_reg;
  // divider reset and the software run bit both stop the chain
  wire run_w = ctrl_run_reg && !mr_f;
  // crystal when high, external clock when low
  wire ref_tick = pin_f_reg[P_RSEL] ? pin_rise[P_XTAL] : pin_rise[P_REF];
  // high runs the pll, low feeds the reference around the oscillator
  wire vco_tick = byp_f ? 1'b1 : ref_tick;
  wire [FB_W-1:0] m_eff = (fb_reg == '0) ? FB_ONE : fb_reg;
  wire [FB_W-1:0] m_last = m_eff - FB_ONE;
  wire fb_wrap = fb_cnt_reg >= m_last;
  wire [FB_W-1:0] fb_cnt_next = fb_wrap ? '0 : fb_cnt_reg + FB_ONE;
  // ratio chosen per output divider code
  wire [3:0] ratio_log = OUT_RATIO_LOG2[{out_reg, 2'b00} +: 4];
  wire [15:0] ratio_last = (16'h0001 << ratio_log) - 16'h0001;
  wire out_wrap = out_cnt_reg >= ratio_last;
  wire fb_in_range = ({{(16-FB_W){1'b0}}, fb_reg} >= FB_MIN) &&
    ({{(16-FB_W){1'b0}}, fb_reg} <= FB_MAX);

  // feedback divider counts oscillator cycles modulo the loaded value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fb_cnt_reg <= '0;
      fb_div_out <= 1'b0;
    end else if (clk_en) begin
      if (!run_w) begin
        fb_cnt_reg <= '0;
        fb_div_out <= 1'b0;
      end else if (byp_f) begin
        fb_cnt_reg <= fb_cnt_next;
        fb_div_out <= fb_cnt_next < (m_eff >> 1);
      end
    end
  end

  // toggling each ratio ticks keeps the duty at half for all ratios
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_cnt_reg <= '0;
      synth_out <= 1'b0;
      synth_out_n <= 1'b1;
    end else if (clk_en) begin
      if (!run_w) begin
        out_cnt_reg <= '0;
        synth_out <= 1'b0;
        synth_out_n <= 1'b1;
      end else if (vco_tick) begin
        out_cnt_reg <= out_wrap ? 16'h0000 : out_cnt_reg + 16'h0001;
        if (out_wrap) begin
          synth_out <= !synth_out;
          synth_out_n <= synth_out;
        end
      end
    end
  end

  logic test_next;
  always_comb begin
    case (sdcl_pkg::sdcl_test_t'(test_reg))
      sdcl_pkg::SDCL_TST_LOW: test_next = 1'b0;
      sdcl_pkg::SDCL_TST_SDATA: test_next = sdat_f;
      sdcl_pkg::SDCL_TST_FB: test_next = fb_div_out;
      sdcl_pkg::SDCL_TST_FOUT: test_next = synth_out;
      default: test_next = 1'b0;
    endcase
  end

  // parallel mode forces the test pin low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      test_out <= 1'b0;
    end else if (clk_en) begin
      test_out <= par_f ? test_next : 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // address and data are held until the response is taken, one write at a time
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = awaddr_reg[7:2] == OFS_CTRL[7:2];
  wire [15:0] cfg_w = {{(16-CW){1'b0}}, test_reg, out_reg, fb_reg};
  wire [31:0] status_w = {12'h000, byp_f, fb_in_range, mode_reg, cfg_w};
  wire [31:0] shift_w = {16'h0000, {(16-CW){1'b0}}, shift_reg};
  wire rd_ctrl = s_axi_araddr[7:2] == OFS_CTRL[7:2];
  wire rd_stat = s_axi_araddr[7:2] == OFS_STATUS[7:2];
  wire rd_shift = s_axi_araddr[7:2] == OFS_SHIFT[7:2];
  wire rd_hit = rd_ctrl || rd_stat || rd_shift;
  wire [31:0] rd_word = rd_ctrl ? {31'h0000_0000, ctrl_run_reg} :
    rd_stat ? status_w : rd_shift ? shift_w : 32'h0000_0000;

  // write channels: each ready drops on its own handshake
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDCL_RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      ctrl_run_reg <= `SDCL_CTRL_RUN_RESET;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ctrl ? `SDCL_RESP_OKAY : `SDCL_RESP_SLVERR;
        if (wr_ctrl && wstrb_reg[0]) begin
          ctrl_run_reg <= wdata_reg[`SDCL_CTRL_RUN_BIT];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SDCL_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `SDCL_RESP_OKAY : `SDCL_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_par_pass: assert property (
    (clk_en && !par_f) |=> (fb_reg == $past(par_src[FB_W-1:0])))
    else $error("parallel pins not passed to feedback divider");

  a_par_hold: assert property (
    (clk_en && par_f && strap_done_reg && !ser_xfer) |=> $stable({out_reg, fb_reg}))
    else $error("divider value changed without a load event");

  a_test_par_low: assert property (
    (clk_en && !par_f) |=> !test_out)
    else $error("test pin not low in parallel mode");

  a_shift_order: assert property (
    (clk_en && par_f && sclk_rise) |=>
    (shift_reg == {$past(shift_reg[CW-2:0]), $past(sdat_f)}))
    else $error("serial bit not shifted in at lsb");

  a_ser_xfer: assert property (
    (clk_en && ser_xfer) |=> ({test_reg, out_reg, fb_reg} == shift_reg))
    else $error("shift register not copied to dividers");

  a_sld_fall_keep: assert property (
    (clk_en && par_f && sld_fall && !sclk_rise && strap_done_reg) |=>
    $stable({test_reg, out_reg, fb_reg}))
    else $error("divider values lost on serial load fall");

  a_test_sdata: assert property (
    (clk_en && par_f && test_reg == 2'h1) |=> (test_out == $past(sdat_f)))
    else $error("test pin does not follow serial data");

  a_reset_out: assert property (
    (clk_en && mr_f) |=> (!synth_out && synth_out_n && !fb_div_out))
    else $error("outputs not forced by divider reset");

  a_out_compl: assert property (
    synth_out_n == !synth_out)
    else $error("complementary output not inverse of true output");

  a_fb_wrap: assert property (
    (clk_en && run_w && byp_f && fb_wrap) |=> (fb_cnt_reg == '0))
    else $error("feedback counter did not wrap at loaded value");

  a_out_toggle: assert property (
    (clk_en && run_w && vco_tick) |=> (synth_out != $past(synth_out)) == $past(out_wrap))
    else $error("output toggled off its ratio boundary");

endmodule

// *** shared/sdcl_cfg.svh ***
// offsets, field positions, reset values and counts of the divider config loader
// assumes inclusion by bare name from the design files
`ifndef SDCL_CFG_SVH
`define SDCL_CFG_SVH
// register byte offsets on the axi4-lite slave
`define SDCL_OFS_CTRL 8'h00
`define SDCL_OFS_STATUS 8'h04
`define SDCL_OFS_SHIFT 8'h08
// control register: run enable in bit 0
`define SDCL_CTRL_RUN_BIT 0
`define SDCL_CTRL_RUN_RESET 1'h1
// strap capture done flag at reset, clear so the capture runs once
`define SDCL_CFG_RESET 1'h0
// feedback values that lock with a 25 MHz reference
`define SDCL_FB_MIN 16'h000A
`define SDCL_FB_MAX 16'h001C
// axi responses
`define SDCL_RESP_OKAY 2'h0
`define SDCL_RESP_SLVERR 2'h2
// synchroniser fill cycles before the strap pins are trusted
`define SDCL_SYNC_FILL 2'h3
// log2 of the output divide ratio, one nibble per output divider code
`define SDCL_OUT_RATIO_LOG2 16'h3210
`endif

// *** shared/sdcl_pkg.sv ***
// types shared by the divider config loader
// assumes nothing of its surroundings
package sdcl_pkg;
  // loader operating mode, reported in status
  typedef enum logic [1:0] {
    SDCL_MODE_PAR,
    SDCL_MODE_SHIFT,
    SDCL_MODE_PASS
  } sdcl_mode_t;
  // test pin source selection
  typedef enum logic [1:0] {
    SDCL_TST_LOW,
    SDCL_TST_SDATA,
    SDCL_TST_FB,
    SDCL_TST_FOUT
  } sdcl_test_t;
endpackage

// *** test/sdcl_host_model.sv ***
// far-side model: strap pins and the serial controller of the loader
// assumes the bench calls its tasks; every pin holds each level at least 6 cycles
`timescale 1ns/1ns

module sdcl_host_model (
  input wire logic clk_sys,
  output logic [8:0] fb_div_bits,
  output logic [1:0] out_div_bits,
  output logic par_load_strobe_n,
  output logic ser_clock,
  output logic ser_data,
  output logic ser_load
);
  // three times the filter minimum of two samples, so no level is ever dropped
  localparam int HOLD = 6;

  // straps tied before reset; shift clock idles low, data at pulldown level
  initial begin
    fb_div_bits = 9'h014;
    out_div_bits = 2'h1;
    par_load_strobe_n = 1'b1;
    {ser_clock, ser_data, ser_load} = 3'h0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic set_pins(input logic [8:0] fb, input logic [1:0] od);
    @(posedge clk_sys);
    fb_div_bits <= fb;
    out_div_bits <= od;
    idle(HOLD);
  endtask

  task automatic set_strobe(input logic v);
    @(posedge clk_sys);
    par_load_strobe_n <= v;
    idle(8);
  endtask

  task automatic set_load(input logic v);
    @(posedge clk_sys);
    ser_load <= v;
    idle(8);
  endtask

  task automatic set_data(input logic v);
    @(posedge clk_sys);
    ser_data <= v;
    idle(8);
  endtask

  task automatic shift(input logic [12:0] w);
    for (int i = 12; i >= 0; i--) begin
      @(posedge clk_sys);
      ser_data <= w[i];
      idle(HOLD);
      ser_clock <= 1'b1;
      idle(HOLD);
      ser_clock <= 1'b0;
    end
    idle(HOLD);
    ser_data <= 1'b0;
    idle(HOLD);
  endtask
endmodule

// *** test/test_synth_divider_config_loader.sv ***
// self-checking bench of the divider config loader
// assumes the host model owns strap and serial pins, the bench the rest
`timescale 1ns/1ns

module test_synth_divider_config_loader;
  typedef struct {string nm; logic [33:0] v;} sdcl_note_t;
  logic clk_sys, reset_n, clk_en, divider_reset, ref_source_select, pll_bypass_select;
  logic xtal_clk, ref_clk, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ser_clock, ser_data, ser_load, par_load_strobe_n;
  logic synth_out, synth_out_n, test_out, fb_div_out;
  logic [8:0] fb_div_bits, cur_fb;
  logic [1:0] out_div_bits, s_axi_bresp, s_axi_rresp, cur_od, cur_ts;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [12:0] word;
  sdcl_note_t rq[$], bq[$], note_r, note_b;
  integer seed = 32'h9a34;
  int err_total = 0, n_compared = 0, xt_cnt = 0, rf_cnt = 0, hi, per, m;

  sdcl_top u_dut (.clk_sys, .reset_n, .clk_en, .fb_div_bits, .out_div_bits, .par_load_strobe_n,
    .ser_clock, .ser_data, .ser_load, .divider_reset, .ref_source_select, .pll_bypass_select,
    .xtal_clk, .ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .synth_out, .synth_out_n, .test_out, .fb_div_out);
  sdcl_host_model u_host (.clk_sys, .fb_div_bits, .out_div_bits, .par_load_strobe_n,
    .ser_clock, .ser_data, .ser_load);

  // ====
  // clocks and watchers
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // free references: crystal period 16 cycles, external period 10, so bypass shows which
  always @(posedge clk_sys) begin
    xt_cnt <= (xt_cnt == 7) ? 0 : xt_cnt + 1;
    rf_cnt <= (rf_cnt == 4) ? 0 : rf_cnt + 1;
    if (xt_cnt == 7) xtal_clk <= ~xtal_clk;
    if (rf_cnt == 4) ref_clk <= ~ref_clk;
  end

  // each bus answer retires the oldest note of its channel
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      note_r = rq.pop_front();
      check(note_r.nm, {s_axi_rresp, s_axi_rdata}, note_r.v);
    end
    if (s_axi_bvalid && s_axi_bready) begin
      note_b = bq.pop_front();
      check(note_b.nm, {32'h0000_0000, s_axi_bresp}, note_b.v);
    end
  end

  // the run needs a few thousand cycles; a hang ends here
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    print_verdict();
  end

  // ====
  // tasks
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
    bq.push_back('{$sformatf("bresp_%h", a), {32'h0000_0000, r}});
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    // no cycle count is assumed; only the watchdog ends a hung wait
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back('{$sformatf("rdata_%h", a), {r, d}});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask

  // status word expected from the loaded values and the mode
  function automatic logic [31:0] st(input logic [1:0] md);
    st = {12'h000, pll_bypass_select, cur_fb >= 9'h00a && cur_fb <= 9'h01c, md, 3'h0,
      cur_ts, cur_od, cur_fb};
  endfunction

  function automatic logic pick(input logic fo);
    return fo ? synth_out : fb_div_out;
  endfunction

  // rise-to-rise period and high time, sampled at falling edges
  task automatic period(input logic fo);
    logic p;
    p = 1'b1;
    for (int k = 0; k < 400 && !(pick(fo) && !p); k++) begin
      p = pick(fo);
      @(negedge clk_sys);
    end
    hi = 0;
    per = 0;
    do begin
      hi += pick(fo);
      per++;
      p = pick(fo);
      @(negedge clk_sys);
    end while (per < 400 && !(pick(fo) && !p));
  endtask

  // test pin must repeat the chosen source one edge later
  task automatic follow(input logic fo);
    logic p;
    @(negedge clk_sys);
    p = pick(fo);
    repeat (30) begin
      @(negedge clk_sys);
      check("test_follow", test_out, p);
      p = pick(fo);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ====
  // scenarios
  initial begin
    {reset_n, divider_reset, xtal_clk, ref_clk} = 4'h0;
    {clk_en, ref_source_select, pll_bypass_select} = 3'h7;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {cur_ts, cur_od, cur_fb} = {2'h0, 2'h1, 9'h014};
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    axi_rd(8'h04, st(2'h1), 2'h0);
    // control register and refused places for a read and a write
    axi_rd(8'h00, 32'h0000_0001, 2'h0);
    axi_rd(8'h0c, 32'h0000_0000, 2'h2);
    axi_wr(8'h04, 32'h0000_0001, 4'hf, 2'h2);
    // random upper lanes; only lane 0 decides whether the run bit is written
    axi_wr(8'h00, 32'h0000_0000, 4'($random(seed)) | 4'h1, 2'h0);
    axi_wr(8'h00, 32'h0000_0001, 4'($random(seed)) & 4'he, 2'h0);
    axi_rd(8'h00, 32'h0000_0000, 2'h0);
    repeat (8) @(negedge clk_sys);
    check("stopped", {synth_out, synth_out_n, fb_div_out}, 3'h2);
    axi_wr(8'h00, 32'h0000_0001, 4'hf, 2'h0);
    for (int t = 0; t < 4; t++) begin
      m = 10 + {$random(seed)} % 19;
      word = {t[1:0], 2'(t + 1), 9'(m)};
      u_host.shift(word);
      axi_rd(8'h08, {19'h0_0000, word}, 2'h0);
      axi_rd(8'h04, st(2'h1), 2'h0);
      u_host.set_load(1'b1);
      {cur_ts, cur_od, cur_fb} = word;
      axi_rd(8'h04, st(2'h2), 2'h0);
      u_host.set_load(1'b0);
      axi_rd(8'h04, st(2'h1), 2'h0);
      case (t)
        0: check("test_low", test_out, 1'b0);
        1: begin
          u_host.set_data(1'b1);
          check("test_data", test_out, 1'b1);
          u_host.set_data(1'b0);
          check("test_data", test_out, 1'b0);
        end
        default: follow(t == 3);
      endcase
    end
    // parallel loads, every output code, test select still 3
    for (int c = 0; c < 4; c++) begin
      m = 10 + {$random(seed)} % 19;
      u_host.set_pins(9'(m), 2'(c));
      u_host.set_strobe(1'b0);
      {cur_od, cur_fb} = {2'(c), 9'(m)};
      axi_rd(8'h04, st(2'h0), 2'h0);
      check("test_par", test_out, 1'b0);
      u_host.set_strobe(1'b1);
      u_host.set_pins(~9'(m), ~2'(c));
      axi_rd(8'h04, st(2'h1), 2'h0);
      period(1'b0);
      check("fb_period", hi * 256 + per, m / 2 * 256 + m);
      period(1'b1);
      check("out_period", hi * 256 + per, (1 << c) * 258);
    end
    // load held high while shifting
    m = 10 + {$random(seed)} % 19;
    word = {4'h0, 9'(m)};
    u_host.set_load(1'b1);
    u_host.shift(word);
    {cur_ts, cur_od, cur_fb} = word;
    axi_rd(8'h04, st(2'h2), 2'h0);
    u_host.set_load(1'b0);
    // random stalls: divide-by-one output moves only on enabled edges
    @(negedge clk_sys);
    hi = synth_out;
    repeat (40) begin
      @(posedge clk_sys);
      hi ^= clk_en;
      clk_en <= 1'($random(seed));
      @(negedge clk_sys);
      check("clk_en_freeze", synth_out, hi[0]);
    end
    @(posedge clk_sys);
    clk_en <= 1'b1;
    divider_reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    repeat (16) begin
      @(negedge clk_sys);
      check("div_reset", {synth_out, synth_out_n, fb_div_out}, 3'h2);
    end
    axi_rd(8'h04, st(2'h1), 2'h0);
    divider_reset <= 1'b0;
    // reference order is random; crystal period 16 cycles, external 10
    m = {$random(seed)} % 2;
    ref_source_select <= 1'(m);
    pll_bypass_select <= 1'b0;
    repeat (80) @(posedge clk_sys);
    period(1'b1);
    check("bypass_first", hi * 256 + per, (m == 1) ? 16 * 256 + 32 : 10 * 256 + 20);
    ref_source_select <= ~1'(m);
    repeat (80) @(posedge clk_sys);
    period(1'b1);
    check("bypass_second", hi * 256 + per, (m == 1) ? 10 * 256 + 20 : 16 * 256 + 32);
    print_verdict();
  end
endmodule
